// ===== src/watchdog_timer_control.sv
// Functional notes
// - the reset-enable bit may be cleared, or the time-out select changed, only while unlocked.
// - the change-unlock bit clears itself four system clocks after software sets it.
// - while the reset-cause flag is set the reset-enable bit is forced to one.
// - the four-bit time-out select sits at bit 5 and bits 2..0 of the control register.
// - select codes 0 to 9 give 2048 doubling to 1048576 oscillator cycles; 10 to 15 are reserved.
// - a watchdog system reset restarts execution at program address zero.
// - the reset-cause flag is set by a watchdog reset, cleared by writing zero or by power-on.
// - with both enables set the first time-out interrupts; the interrupt acknowledge then drops to reset-only mode.
`timescale 1ns/1ps
module watchdog_timer_control #(
  parameter int CNT_W = wdt_ctrl_pkg::CNT_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // watchdog oscillator tick pin and cpu hooks
  input wire logic osc_pin,
  input wire logic kick,
  input wire logic irq_ack,
  // outputs
  output logic irq,
  output logic sys_reset,
  output logic [15:0] reset_vector
);
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_flag_r, irq_flag_nxt, irq_en_r, irq_en_nxt;
  logic unlock_r, unlock_nxt, rst_en_r, rst_en_nxt;
  logic [2:0] unlock_cnt_r, unlock_cnt_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic cause_r, cause_nxt, sysrst_r, sysrst_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic tick, timeout, wr_ctrl, wr_cause;
  logic [3:0] wsel;
  logic [CNT_W-1:0] limit;

  assign wr_ctrl = wr && addr == wdt_ctrl_pkg::ADDR_CTRL;
  assign wr_cause = wr && addr == wdt_ctrl_pkg::ADDR_CAUSE;
  assign wsel = {wdata[wdt_ctrl_pkg::BIT_SEL3],
                 wdata[wdt_ctrl_pkg::BIT_SEL_HI:wdt_ctrl_pkg::BIT_SEL_LO]};
  // reserved codes saturate at the longest time-out
  assign limit = wdt_ctrl_pkg::BASE_COUNT <<
                 ((sel_r > wdt_ctrl_pkg::SEL_MAX) ? wdt_ctrl_pkg::SEL_MAX : sel_r);
  assign tick = osc_s2_r & ~osc_s3_r;
  // at-or-past, so a shorter select chosen mid-count still ends the period
  assign timeout = tick && (rst_en_r || irq_en_r) && cnt_r >= limit - 1'b1;

  // oscillator pin crosses in through two flops; third flop only for the edge
  always_ff @(posedge core_clk) begin
    osc_s1_r <= osc_pin;
    osc_s2_r <= osc_s1_r;
    osc_s3_r <= osc_s2_r;
  end

  always_comb begin
    irq_flag_nxt = irq_flag_r;
    irq_en_nxt = irq_en_r;
    unlock_nxt = unlock_r;
    unlock_cnt_nxt = unlock_cnt_r;
    rst_en_nxt = rst_en_r;
    sel_nxt = sel_r;
    cause_nxt = cause_r;
    sysrst_nxt = 1'b0;
    cnt_nxt = cnt_r;
    rdata_nxt = 8'h00;
    if (rd) begin
      if (addr == wdt_ctrl_pkg::ADDR_CTRL) begin
        rdata_nxt = {irq_flag_r, irq_en_r, sel_r[3], unlock_r, rst_en_r, sel_r[2:0]};
      end else if (addr == wdt_ctrl_pkg::ADDR_CAUSE) begin
        rdata_nxt[wdt_ctrl_pkg::BIT_CAUSE] = cause_r;
      end
    end
    if (unlock_r) begin
      unlock_cnt_nxt = unlock_cnt_r + 3'h1;
      if (unlock_cnt_r == wdt_ctrl_pkg::UNLOCK_CYCLES - 3'h1) begin
        unlock_nxt = 1'b0;
      end
    end
    if (wr_cause && !wdata[wdt_ctrl_pkg::BIT_CAUSE]) begin
      cause_nxt = 1'b0;
    end
    if (wr_ctrl) begin
      irq_en_nxt = wdata[wdt_ctrl_pkg::BIT_IRQ_EN];
      if (wdata[wdt_ctrl_pkg::BIT_IRQ_FLAG]) begin
        irq_flag_nxt = 1'b0;
      end
      if (wdata[wdt_ctrl_pkg::BIT_RST_EN]) begin
        rst_en_nxt = 1'b1;
      end else if (unlock_r) begin
        rst_en_nxt = 1'b0;
      end
      if (unlock_r) begin
        sel_nxt = wsel;
      end
      // a fresh unlock needs the reset-enable bit written one alongside
      if (wdata[wdt_ctrl_pkg::BIT_UNLOCK] && wdata[wdt_ctrl_pkg::BIT_RST_EN]) begin
        unlock_nxt = 1'b1;
        unlock_cnt_nxt = 3'h0;
      end else if (!wdata[wdt_ctrl_pkg::BIT_UNLOCK]) begin
        unlock_nxt = 1'b0;
      end
    end
    if (irq_ack) begin
      irq_flag_nxt = 1'b0;
      irq_en_nxt = 1'b0;
    end
    // a stopped watchdog holds zero, so enabling it starts a full period
    if (kick || !(rst_en_r || irq_en_r)) begin
      cnt_nxt = '0;
    end else if (tick) begin
      cnt_nxt = timeout ? '0 : cnt_r + 1'b1;
    end
    if (timeout) begin
      if (irq_en_r && !irq_flag_r) begin
        irq_flag_nxt = 1'b1;
      end else if (rst_en_r) begin
        sysrst_nxt = 1'b1;
        cause_nxt = 1'b1;
      end
    end
    if (cause_nxt) begin
      rst_en_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      irq_flag_r <= 1'b0;
      irq_en_r <= 1'b0;
      unlock_r <= 1'b0;
      unlock_cnt_r <= 3'h0;
      // cause flag is untouched by this reset, so reset-enable restarts forced
      rst_en_r <= cause_r;
      sel_r <= wdt_ctrl_pkg::SEL_RESET;
      cnt_r <= '0;
      sysrst_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      irq_flag_r <= irq_flag_nxt;
      irq_en_r <= irq_en_nxt;
      unlock_r <= unlock_nxt;
      unlock_cnt_r <= unlock_cnt_nxt;
      rst_en_r <= rst_en_nxt | cause_nxt;
      sel_r <= sel_nxt;
      cnt_r <= cnt_nxt;
      sysrst_r <= sysrst_nxt;
    end
  end

  // cause flag survives the watchdog reset itself; only power-on or writing zero to the cause bit clears it
  always_ff @(posedge core_clk) begin
    if (por) begin
      cause_r <= 1'b0;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_flag_r & irq_en_r;
  assign sys_reset = sysrst_r;
  assign reset_vector = wdt_ctrl_pkg::RESET_VECTOR;

  // unlock window: exactly four cycles unless software rewrites the register
  a_unlock_holds: assert property (@(posedge core_clk) disable iff (rst)
    $rose(unlock_r) ##0 (!wr_ctrl) [*3] |=> unlock_r)
    else $error("unlock bit dropped early");
  a_unlock_expires: assert property (@(posedge core_clk) disable iff (rst)
    $rose(unlock_r) ##0 (!wr_ctrl) [*4] |=> !unlock_r)
    else $error("unlock bit outlived four cycles");
  a_cause_forces_en: assert property (@(posedge core_clk) disable iff (rst)
    cause_r |-> rst_en_r)
    else $error("reset enable low while cause flag set");
  a_locked_sel: assert property (@(posedge core_clk) disable iff (rst)
    !unlock_r |=> $stable(sel_r))
    else $error("select changed while locked");
  a_locked_en: assert property (@(posedge core_clk) disable iff (rst)
    !unlock_r && rst_en_r |=> rst_en_r)
    else $error("reset enable cleared while locked");
  a_reset_cause: assert property (@(posedge core_clk) disable iff (rst || por)
    sys_reset |-> cause_r)
    else $error("system reset without cause flag");
  // time-out actions per mode
  a_first_irq: assert property (@(posedge core_clk) disable iff (rst)
    timeout && irq_en_r && !irq_flag_r |=> irq_flag_r && !sys_reset)
    else $error("first time-out did not interrupt");
  a_ack_reset_only: assert property (@(posedge core_clk) disable iff (rst)
    irq_ack |=> !irq_en_r)
    else $error("interrupt enable kept after vector");
  a_second_timeout: assert property (@(posedge core_clk) disable iff (rst)
    timeout && rst_en_r && !(irq_en_r && !irq_flag_r) |=> sys_reset)
    else $error("reset-mode time-out did not reset");
  a_no_reset_stopped: assert property (@(posedge core_clk) disable iff (rst)
    !rst_en_r |=> !sys_reset)
    else $error("system reset with reset enable clear");
  a_kick_clears: assert property (@(posedge core_clk) disable iff (rst)
    kick |=> cnt_r == '0)
    else $error("counter not restarted");
  a_stopped_idle: assert property (@(posedge core_clk) disable iff (rst)
    !(rst_en_r || irq_en_r) |=> cnt_r == '0)
    else $error("counter moved while stopped");
  a_vector_zero: assert property (@(posedge core_clk)
    sys_reset |-> reset_vector == 16'h0000)
    else $error("reset vector not zero");
  a_sel_field: assert property (@(posedge core_clk) disable iff (rst)
    wr_ctrl && unlock_r |=> sel_r == $past(wsel))
    else $error("select field not taken");
  c_unlock: cover property (@(posedge core_clk) disable iff (rst) $rose(unlock_r));
  c_irq: cover property (@(posedge core_clk) disable iff (rst) $rose(irq_flag_r));
  c_sysrst: cover property (@(posedge core_clk) disable iff (rst) sys_reset);
  c_protected_clear: cover property (@(posedge core_clk) disable iff (rst)
    unlock_r && wr_ctrl && !wdata[wdt_ctrl_pkg::BIT_RST_EN]);
  c_forced_en: cover property (@(posedge core_clk) disable iff (rst)
    cause_r && unlock_r && wr_ctrl && !wdata[wdt_ctrl_pkg::BIT_RST_EN]);
endmodule

// ===== src/wdt_ctrl_pkg.sv
package wdt_ctrl_pkg;
  // register map, byte addresses on the plain port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CAUSE = 4'h1;
  // control register fields
  localparam int BIT_IRQ_FLAG = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_SEL3 = 5;
  localparam int BIT_UNLOCK = 4;
  localparam int BIT_RST_EN = 3;
  localparam int BIT_SEL_HI = 2;
  localparam int BIT_SEL_LO = 0;
  // cause register field
  localparam int BIT_CAUSE = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h9;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] BASE_COUNT = 21'h000800;
endpackage

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic osc_pin = 1'b0;
  logic kick = 1'b0;
  logic irq_ack = 1'b0;
  logic irq;
  logic sys_reset;
  logic [15:0] reset_vector;
  logic [7:0] d;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int resets = 0;
  watchdog_timer_control dut (.core_clk(core_clk), .rst(rst), .por(por), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_pin(osc_pin), .kick(kick),
    .irq_ack(irq_ack), .irq(irq), .sys_reset(sys_reset), .reset_vector(reset_vector));
  always #25 core_clk = ~core_clk;
  // hang guard: the tick phases need about 20.4k cycles
  always @(posedge core_clk) begin
    cycles++;
    if (sys_reset === 1'b1) resets++;
    if (cycles == 60000) begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse_pin(input int which);
    @(posedge core_clk);
    if (which == 0) kick <= 1'b1; else irq_ack <= 1'b1;
    @(posedge core_clk);
    kick <= 1'b0;
    irq_ack <= 1'b0;
    // checks after a call see settled outputs
    @(negedge core_clk);
  endtask
  // slow oscillator: one tick every four system clocks, well inside the synchroniser
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk) osc_pin <= 1'b1;
      repeat (2) @(posedge core_clk);
      osc_pin <= 1'b0;
      @(posedge core_clk);
    end
    @(negedge core_clk);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    por <= 1'b0;
    rreg(wdt_ctrl_pkg::ADDR_CTRL, d); `CHK(d, 8'h00)
    rreg(wdt_ctrl_pkg::ADDR_CAUSE, d); `CHK(d, 8'h00)
    $display("test reset values done");
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h08);
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h00);
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h0d);
    rreg(wdt_ctrl_pkg::ADDR_CTRL, d); `CHK(d, 8'h08)
    // walk down through reserved codes so the field ends at the shortest time-out
    for (int s = 15; s >= 0; s--) begin
      wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h18);
      wreg(wdt_ctrl_pkg::ADDR_CTRL, {2'h0, s[3], 2'h1, s[2:0]});
      rreg(wdt_ctrl_pkg::ADDR_CTRL, d); `CHK(d, {2'h0, s[3], 2'h1, s[2:0]})
    end
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h18);
    rreg(wdt_ctrl_pkg::ADDR_CTRL, d); `CHK(d, 8'h18)
    repeat (4) @(posedge core_clk);
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h00);
    rreg(wdt_ctrl_pkg::ADDR_CTRL, d); `CHK(d, 8'h08)
    $display("test protected change done");
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h48);
    pulse_pin(0);
    ticks(1000);
    pulse_pin(0);
    ticks(2047); `CHK(irq, 1'b0)
    ticks(1); `CHK(irq, 1'b1)
    `CHK(resets, 0)
    pulse_pin(1); `CHK(irq, 1'b0)
    ticks(2047); `CHK(sys_reset, 1'b0)
    ticks(1); `CHK(sys_reset, 1'b1)
    `CHK(reset_vector, 16'h0000)
    @(posedge core_clk) rst <= 1'b1;
    @(posedge core_clk) rst <= 1'b0;
    `CHK(resets, 1)
    rreg(wdt_ctrl_pkg::ADDR_CAUSE, d); `CHK(d, 8'h08)
    rreg(wdt_ctrl_pkg::ADDR_CTRL, d); `CHK(d, 8'h08)
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h18);
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h00);
    rreg(wdt_ctrl_pkg::ADDR_CTRL, d); `CHK(d, 8'h08)
    wreg(wdt_ctrl_pkg::ADDR_CAUSE, 8'h00);
    rreg(wdt_ctrl_pkg::ADDR_CAUSE, d); `CHK(d, 8'h00)
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h18);
    wreg(wdt_ctrl_pkg::ADDR_CTRL, 8'h00);
    rreg(wdt_ctrl_pkg::ADDR_CTRL, d); `CHK(d, 8'h00)
    $display("test time-out and cause done");
    conclude();
  end
endmodule
